// ===== exec_subset_defines.vh
// How it works
// - Nibble exchange loads swapped byte into working
// - Skip when addressed byte equals zero
// - Taken skip costs two instruction cycles
// - Copy byte to working, skip if zero
// - Skip when selected bit is zero
// - Paged table read: low to memory, high latch
// - Last-page read addressed by low pointer alone
// - Preincrement low pointer, then paged read
// - Preincrement low pointer, then last-page read
// - XOR with byte or immediate, zero flag
// - Far forms reach any memory section
// - Add with carry updates five flags
// - Add without carry updates five flags
// - AND updates only zero flag
// - Far clear writes zero, flags kept
// - Far bit clear touches selected bit only
// - Complement to memory or working, zero flag
// - BCD adjust adds six per nibble
// - BCD adjust may only set carry
// - Decrement to memory or working, zero flag
// - Increment to memory or working, zero flag
// - Far move copies byte either direction
`ifndef EXEC_SUBSET_DEFINES_VH
`define EXEC_SUBSET_DEFINES_VH
// APB register byte offsets
`define REG_CTRL 12'h000
`define REG_OPERAND 12'h004
`define REG_WORKING 12'h008
`define REG_FLAGS 12'h00c
`define REG_TABLE_PTR 12'h010
`define REG_PROG_WORD 12'h014
`define REG_RESULT 12'h018
`define REG_STATUS 12'h01c
// Control fields: go at bit 0, opcode at 12:8, bit select at 18:16
`define CTRL_GO_BIT 0
`define CTRL_OP_LSB 8
`define CTRL_BIT_LSB 16
// Flag positions in the flag register
`define FLAG_C 0
`define FLAG_HC 1
`define FLAG_Z 2
`define FLAG_SW 3
`define FLAG_SGC 4
// Operation codes
`define OP_NOP 5'h00
`define OP_NIBX 5'h01
`define OP_SKZ 5'h02
`define OP_SKZA 5'h03
`define OP_SKZBIT 5'h04
`define OP_TRD 5'h05
`define OP_TRDL 5'h06
`define OP_ITRD 5'h07
`define OP_ITRDL 5'h08
`define OP_XOR 5'h09
`define OP_XOR_MEM 5'h0a
`define OP_XORI 5'h0b
`define OP_ADC 5'h0c
`define OP_ADCM 5'h0d
`define OP_ADD 5'h0e
`define OP_ADDM 5'h0f
`define OP_AND 5'h10
`define OP_ANDM 5'h11
`define OP_CLR 5'h12
`define OP_CLRBIT 5'h13
`define OP_CPL 5'h14
`define OP_CPLA 5'h15
`define OP_DAA 5'h16
`define OP_DEC 5'h17
`define OP_DECA 5'h18
`define OP_INC 5'h19
`define OP_INCA 5'h1a
`define OP_MOVA 5'h1b
`define OP_MOVM 5'h1c
// Reset values, last table page and skip cycle count
`define FLAGS_RST 5'h00
`define BYTE_RST 8'h00
`define LAST_PAGE 8'hff
`define SKIP_CYCLES 2'h2
`endif

// ===== exec_subset.v
`timescale 1ns/10ps
`include "exec_subset_defines.vh"
module exec_subset (
    // APB
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr
);
    reg [7:0] operand_q;
    reg [7:0] working_q;
    reg [4:0] flags_q;
    reg [7:0] table_pointer_low_q;
    reg [7:0] table_pointer_high_q;
    reg [15:0] prog_word_q;
    reg [7:0] table_read_high_latch_q;
    reg [7:0] result_q;
    reg [4:0] op_q;
    reg [2:0] bit_sel_q;
    reg [1:0] cycles_q;
    reg skip_q;
    reg mem_write_q;
    reg discard_q;
    reg [15:0] prog_addr_q;

    wire wr_en = psel & penable & pwrite;
    wire go = wr_en && (paddr == `REG_CTRL) && pwdata[`CTRL_GO_BIT];
    wire [4:0] go_op = pwdata[`CTRL_OP_LSB+4:`CTRL_OP_LSB];
    wire [2:0] go_bit = pwdata[`CTRL_BIT_LSB+2:`CTRL_BIT_LSB];

    assign pready = 1'b1;
    assign pslverr = 1'b0;

    // Zero test used by several operations
    function zero8;
        input [7:0] v;
        begin
            zero8 = (v == 8'h00);
        end
    endfunction

    // Adder with all five arithmetic flags; packs {flags, sum}
    function [12:0] add_flags;
        input [7:0] a;
        input [7:0] b;
        input cin;
        input [4:0] fl;
        reg [8:0] s;
        reg [4:0] h;
        reg c7;
        reg [4:0] f;
        begin
            s = {1'b0, a} + {1'b0, b} + {8'h00, cin};
            h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
            c7 = a[7] ^ b[7] ^ s[7];
            f = fl;
            f[`FLAG_C] = s[8];
            f[`FLAG_HC] = h[4];
            f[`FLAG_Z] = zero8(s[7:0]);
            f[`FLAG_SW] = c7 ^ s[8];
            f[`FLAG_SGC] = s[7] ^ (c7 ^ s[8]);
            add_flags = {f, s[7:0]};
        end
    endfunction

    // Decimal adjust: {carry_out, adjusted byte}
    function [8:0] bcd_adjust;
        input [7:0] a;
        input ac;
        input c;
        reg [8:0] s;
        reg lo;
        reg hi;
        begin
            // Both conditions look at the unadjusted working value
            lo = (a[3:0] > 4'h9) || ac;
            hi = (a[7:4] > 4'h9) || c;
            s = {1'b0, a} + (lo ? 9'h006 : 9'h000);
            s = s + (hi ? 9'h060 : 9'h000);
            bcd_adjust = {hi | s[8] | c, s[7:0]};
        end
    endfunction

    // Combinational execution of one operation
    reg [7:0] wk_d;
    reg [4:0] fl_d;
    reg [7:0] res_d;
    reg mw_d;
    reg skip_d;
    reg [12:0] af;
    reg [8:0] bd;
    reg [7:0] tmp;
    always @* begin
        wk_d = working_q;
        fl_d = flags_q;
        res_d = operand_q;
        mw_d = 1'b0;
        skip_d = 1'b0;
        af = 13'h0000;
        bd = 9'h000;
        tmp = 8'h00;
        // Operand arrives already resolved from any section, so far forms need no bank
        case (op_q)
            `OP_NIBX: wk_d = {operand_q[3:0], operand_q[7:4]};
            `OP_SKZ: skip_d = zero8(operand_q);
            `OP_SKZA: begin
                wk_d = operand_q;
                skip_d = zero8(operand_q);
            end
            `OP_SKZBIT: skip_d = ~operand_q[bit_sel_q];
            `OP_TRD, `OP_TRDL, `OP_ITRD, `OP_ITRDL: begin
                res_d = prog_word_q[7:0];
                mw_d = 1'b1;
            end
            `OP_XOR, `OP_XORI, `OP_XOR_MEM: begin
                tmp = working_q ^ operand_q;
                fl_d[`FLAG_Z] = zero8(tmp);
                if (op_q == `OP_XOR_MEM) begin
                    res_d = tmp;
                    mw_d = 1'b1;
                end else begin
                    wk_d = tmp;
                end
            end
            `OP_ADC, `OP_ADCM, `OP_ADD, `OP_ADDM: begin
                af = add_flags(working_q, operand_q,
                    ((op_q == `OP_ADC) || (op_q == `OP_ADCM)) & flags_q[`FLAG_C],
                    flags_q);
                fl_d = af[12:8];
                if ((op_q == `OP_ADCM) || (op_q == `OP_ADDM)) begin
                    res_d = af[7:0];
                    mw_d = 1'b1;
                end else begin
                    wk_d = af[7:0];
                end
            end
            `OP_AND, `OP_ANDM: begin
                tmp = working_q & operand_q;
                fl_d[`FLAG_Z] = zero8(tmp);
                if (op_q == `OP_ANDM) begin
                    res_d = tmp;
                    mw_d = 1'b1;
                end else begin
                    wk_d = tmp;
                end
            end
            `OP_CLR: begin
                res_d = `BYTE_RST;
                mw_d = 1'b1;
            end
            `OP_CLRBIT: begin
                res_d = operand_q & ~(8'h01 << bit_sel_q);
                mw_d = 1'b1;
            end
            `OP_CPL, `OP_CPLA: begin
                tmp = ~operand_q;
                fl_d[`FLAG_Z] = zero8(tmp);
                if (op_q == `OP_CPL) begin
                    res_d = tmp;
                    mw_d = 1'b1;
                end else begin
                    wk_d = tmp;
                end
            end
            `OP_DAA: begin
                bd = bcd_adjust(working_q, flags_q[`FLAG_HC], flags_q[`FLAG_C]);
                res_d = bd[7:0];
                mw_d = 1'b1;
                fl_d[`FLAG_C] = bd[8];
            end
            `OP_DEC, `OP_DECA, `OP_INC, `OP_INCA: begin
                if ((op_q == `OP_DEC) || (op_q == `OP_DECA)) begin
                    tmp = operand_q - 8'h01;
                end else begin
                    tmp = operand_q + 8'h01;
                end
                fl_d[`FLAG_Z] = zero8(tmp);
                if ((op_q == `OP_DEC) || (op_q == `OP_INC)) begin
                    res_d = tmp;
                    mw_d = 1'b1;
                end else begin
                    wk_d = tmp;
                end
            end
            `OP_MOVA: wk_d = operand_q;
            `OP_MOVM: begin
                res_d = working_q;
                mw_d = 1'b1;
            end
            default: begin
                wk_d = working_q;
            end
        endcase
    end

    // Table address: last page ignores the high pointer byte
    reg [7:0] tpl_next;
    always @* begin
        tpl_next = table_pointer_low_q;
        if ((go_op == `OP_ITRD) || (go_op == `OP_ITRDL)) begin
            tpl_next = table_pointer_low_q + 8'h01;
        end
    end

    // Issue, execute and skip tracking; a discarded slot changes only the status fields
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op_q <= `OP_NOP;
            bit_sel_q <= 3'h0;
            working_q <= `BYTE_RST;
            flags_q <= `FLAGS_RST;
            operand_q <= `BYTE_RST;
            table_pointer_low_q <= `BYTE_RST;
            table_pointer_high_q <= `BYTE_RST;
            prog_word_q <= 16'h0000;
            table_read_high_latch_q <= `BYTE_RST;
            result_q <= `BYTE_RST;
            cycles_q <= 2'h0;
            skip_q <= 1'b0;
            mem_write_q <= 1'b0;
            discard_q <= 1'b0;
            prog_addr_q <= 16'h0000;
        end else begin
            op_q <= `OP_NOP;
            if (go) begin
                // Skipped slot: the next instruction retires as a no-op
                if (skip_q) begin
                    discard_q <= 1'b1;
                    skip_q <= 1'b0;
                    cycles_q <= `SKIP_CYCLES;
                end else begin
                    discard_q <= 1'b0;
                    op_q <= go_op;
                    bit_sel_q <= go_bit;
                    cycles_q <= 2'h1;
                    table_pointer_low_q <= tpl_next;
                    if ((go_op == `OP_TRDL) || (go_op == `OP_ITRDL)) begin
                        prog_addr_q <= {`LAST_PAGE, tpl_next};
                    end else begin
                        prog_addr_q <= {table_pointer_high_q, tpl_next};
                    end
                end
            end else if (wr_en) begin
                case (paddr)
                    `REG_OPERAND: operand_q <= pwdata[7:0];
                    `REG_WORKING: working_q <= pwdata[7:0];
                    `REG_FLAGS: flags_q <= pwdata[4:0];
                    `REG_TABLE_PTR: begin
                        table_pointer_low_q <= pwdata[7:0];
                        table_pointer_high_q <= pwdata[15:8];
                    end
                    `REG_PROG_WORD: prog_word_q <= pwdata[15:0];
                    default: begin
                        skip_q <= skip_q;
                    end
                endcase
            end
            if (op_q != `OP_NOP) begin
                working_q <= wk_d;
                flags_q <= fl_d;
                result_q <= res_d;
                mem_write_q <= mw_d;
                skip_q <= skip_d;
                if (skip_d) begin
                    cycles_q <= `SKIP_CYCLES;
                end
                if ((op_q == `OP_TRD) || (op_q == `OP_TRDL) ||
                    (op_q == `OP_ITRD) || (op_q == `OP_ITRDL)) begin
                    table_read_high_latch_q <= prog_word_q[15:8];
                end
            end else if (go) begin
                mem_write_q <= 1'b0;
            end
        end
    end

    // Read mux; unmapped addresses read zero
    always @* begin
        case (paddr)
            `REG_OPERAND: prdata = {24'h000000, operand_q};
            `REG_WORKING: prdata = {24'h000000, working_q};
            `REG_FLAGS: prdata = {27'h0000000, flags_q};
            `REG_TABLE_PTR: prdata = {16'h0000, table_pointer_high_q, table_pointer_low_q};
            `REG_PROG_WORD: prdata = {prog_addr_q, prog_word_q};
            `REG_RESULT: prdata = {16'h0000, table_read_high_latch_q, result_q};
            `REG_STATUS: prdata = {27'h0000000, discard_q, cycles_q, mem_write_q, skip_q};
            default: prdata = 32'h00000000;
        endcase
    end
endmodule

// ===== exec_subset_checker.sv
`timescale 1ns/10ps
`include "exec_subset_defines.vh"
module exec_subset_checker (
    // APB
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire wr = psel && penable && pwrite;
    wire go = wr && paddr == `REG_CTRL && pwdata[0];
    wire [4:0] opw = pwdata[12:8];
    reg [7:0] m_q;
    reg [4:0] op_q;
    reg g_q;
    reg fresh_q;
    reg skp_q;
    wire take = ((opw == `OP_SKZ || opw == `OP_SKZA) && m_q == 8'h00)
        || (opw == `OP_SKZBIT && !m_q[pwdata[18:16]]);
    // Only checked once the op has run and no input register moved since
    wire fr = psel && penable && !pwrite && fresh_q;
    // Shadow of the operand and of the last op that really executed
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            m_q <= 8'h00;
            op_q <= `OP_NOP;
            g_q <= 1'b0;
            fresh_q <= 1'b0;
            skp_q <= 1'b0;
        end else begin
            g_q <= go;
            if (wr && paddr == `REG_OPERAND)
                m_q <= pwdata[7:0];
            if (go) begin
                op_q <= skp_q ? `OP_NOP : opw;
                skp_q <= !skp_q && take;
            end
            if (wr)
                fresh_q <= 1'b0;
            else if (g_q)
                fresh_q <= 1'b1;
        end
    end
    swap_working_a: assert property (fr && paddr == `REG_WORKING && op_q == `OP_NIBX
        |-> prdata[7:0] == {m_q[3:0], m_q[7:4]}) else $error("swap result wrong");
    copy_working_a: assert property (fr && paddr == `REG_WORKING
        && (op_q == `OP_SKZA || op_q == `OP_MOVA) |-> prdata[7:0] == m_q) else $error("copy wrong");
    inc_working_a: assert property (fr && paddr == `REG_WORKING && op_q == `OP_INCA
        |-> prdata[7:0] == m_q + 8'h01) else $error("increment wrong");
    dec_working_a: assert property (fr && paddr == `REG_WORKING && op_q == `OP_DECA
        |-> prdata[7:0] == m_q - 8'h01) else $error("decrement wrong");
    cpl_working_a: assert property (fr && paddr == `REG_WORKING && op_q == `OP_CPLA
        |-> prdata[7:0] == ~m_q) else $error("complement wrong");
    clear_result_a: assert property (fr && paddr == `REG_RESULT && op_q == `OP_CLR
        |-> prdata[7:0] == 8'h00) else $error("clear wrong");
    skip_pending_a: assert property (fr && paddr == `REG_STATUS
        |-> prdata[0] == skp_q) else $error("skip state wrong");
    discard_status_a: assert property (fr && paddr == `REG_STATUS && op_q == `OP_NOP
        |-> prdata[4:2] == 3'h6) else $error("discarded go not reported");
    zero_wait_a: assert property (psel |-> pready && !pslverr) else $error("bus answer wrong");
    // Main scenarios
    cover property (go && skp_q);
    cover property (go && opw == `OP_DAA);
    cover property (fr && op_q == `OP_NIBX);
endmodule
bind exec_subset exec_subset_checker exec_subset_checker_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));

// ===== mcu_instruction_execute_subset_test.sv
`timescale 1ns/10ps
`include "exec_subset_defines.vh"
module mcu_instruction_execute_subset_test;
    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] q;
    wire [31:0] prdata;
    wire pready;
    wire pslverr;
    int errors = 0;
    int samples_checked = 0;
    exec_subset exec_subset_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    // Free-running clock
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    task automatic tally_and_finish;
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %0t got %h want %h", $time, g, e);
        end
    endtask
    // One APB transfer; the request is held until pready is seen high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic go(input logic [4:0] op, input logic [2:0] b);
        apb(1'b1, `REG_CTRL, {13'h0, b, 3'h0, op, 7'h0, 1'b1});
    endtask
    // Load operands, execute, compare against the reference model below
    task automatic run(input logic [4:0] op, input logic [7:0] m, input logic [7:0] w,
        input logic [4:0] f, input logic [15:0] tp, input logic [15:0] pw, input logic [2:0] b);
        logic [8:0] s;
        logic [7:0] v;
        logic [7:0] ew;
        logic [4:0] ef;
        logic [15:0] t2;
        logic ci;
        logic hi;
        logic lo;
        logic mw;
        logic sk;
        logic tb;
        ef = f;
        t2 = tp;
        ci = (op == `OP_ADC || op == `OP_ADCM) ? f[`FLAG_C] : 1'b0;
        s = {1'b0, w} + {1'b0, m} + {8'h00, ci};
        lo = w[3:0] > 4'h9 || f[`FLAG_HC];
        hi = w[7:4] > 4'h9 || f[`FLAG_C];
        case (op)
            `OP_NIBX: v = {m[3:0], m[7:4]};
            `OP_XOR, `OP_XOR_MEM, `OP_XORI: v = w ^ m;
            `OP_AND, `OP_ANDM: v = w & m;
            `OP_CLR: v = 8'h00;
            `OP_CLRBIT: v = m & ~(8'h01 << b);
            `OP_CPL, `OP_CPLA: v = ~m;
            `OP_DAA: v = w + {hi ? 4'h6 : 4'h0, lo ? 4'h6 : 4'h0};
            `OP_DEC, `OP_DECA: v = m - 8'h01;
            `OP_INC, `OP_INCA: v = m + 8'h01;
            `OP_MOVM: v = w;
            default: v = op inside {[`OP_ADC:`OP_ADDM]} ? s[7:0] : m;
        endcase
        if (op inside {[`OP_ADC:`OP_ADDM]}) begin
            ef[`FLAG_C] = s[8];
            ef[`FLAG_HC] = ({1'b0, w[3:0]} + {1'b0, m[3:0]} + {4'h0, ci}) > 5'h0f;
            ef[`FLAG_SW] = w[7] == m[7] && v[7] != w[7];
            ef[`FLAG_SGC] = v[7] ^ ef[`FLAG_SW];
        end
        if (op == `OP_DAA)
            ef[`FLAG_C] = f[`FLAG_C] | hi;
        if (op inside {[`OP_XOR:`OP_ANDM], `OP_CPL, `OP_CPLA, [`OP_DEC:`OP_INCA]})
            ef[`FLAG_Z] = v == 8'h00;
        ew = op inside {`OP_NIBX, `OP_SKZA, `OP_XOR, `OP_XORI, `OP_ADC, `OP_ADD, `OP_AND,
            `OP_CPLA, `OP_DECA, `OP_INCA, `OP_MOVA} ? v : w;
        tb = op inside {[`OP_TRD:`OP_ITRDL]};
        mw = tb || op inside {`OP_XOR_MEM, `OP_ADCM, `OP_ADDM, `OP_ANDM, [`OP_CLR:`OP_CPL],
            `OP_DAA, `OP_DEC, `OP_INC, `OP_MOVM};
        sk = ((op == `OP_SKZ || op == `OP_SKZA) && m == 8'h00) || (op == `OP_SKZBIT && !m[b]);
        if (op == `OP_ITRD || op == `OP_ITRDL)
            t2[7:0] = tp[7:0] + 8'h01;
        apb(1'b1, `REG_OPERAND, {24'h0, m});
        apb(1'b1, `REG_WORKING, {24'h0, w});
        apb(1'b1, `REG_FLAGS, {27'h0, f});
        apb(1'b1, `REG_TABLE_PTR, {16'h0, tp});
        apb(1'b1, `REG_PROG_WORD, {16'h0, pw});
        go(op, b);
        apb(1'b0, `REG_WORKING, 32'h0);
        chk({8'h00, q[7:0]}, {8'h00, ew});
        apb(1'b0, `REG_FLAGS, 32'h0);
        chk({11'h0, q[4:0]}, {11'h0, ef});
        apb(1'b0, `REG_STATUS, 32'h0);
        // Status: not discarded, cycle count, memory write, skip pending
        chk({11'h0, q[4:0]}, {11'h0, 1'b0, (sk ? 2'h2 : 2'h1), mw, sk});
        apb(1'b0, `REG_RESULT, 32'h0);
        if (mw && !tb)
            chk({8'h00, q[7:0]}, {8'h00, v});
        if (tb) begin
            chk(q[15:0], pw);
            apb(1'b0, `REG_PROG_WORD, 32'h0);
            chk(q[31:16], (op == `OP_TRDL || op == `OP_ITRDL) ? {8'hff, t2[7:0]} : t2);
            apb(1'b0, `REG_TABLE_PTR, 32'h0);
            chk(q[15:0], t2);
        end
        if (sk) begin
            go(`OP_INCA, 3'h0);
            apb(1'b0, `REG_WORKING, 32'h0);
            chk({8'h00, q[7:0]}, {8'h00, ew});
            apb(1'b0, `REG_STATUS, 32'h0);
            chk({13'h0, q[4:2]}, 16'h0006);
        end
    endtask
    // Hang guard, well beyond the expected run length
    initial begin
        #200000;
        errors++;
        tally_and_finish;
    end
    initial begin
        logic [31:0] ra;
        logic [31:0] rb;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        presetn = 1'b0;
        void'($urandom(71027));
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        // Unmapped write must be ignored; everything reads zero after reset
        apb(1'b1, 12'h020, 32'hffffffff);
        for (int a = 0; a <= 32; a += 4) begin
            apb(1'b0, 12'(a), 32'h0);
            chk(q[15:0], 16'h0000);
        end
        // Corners: carry-in overflow, decimal adjust, wraps, pointer wrap, skips
        run(`OP_ADC, 8'h7f, 8'h00, 5'h01, 16'h0000, 16'h0000, 3'h0);
        run(`OP_DAA, 8'h00, 8'h5a, 5'h00, 16'h0000, 16'h0000, 3'h0);
        run(`OP_DAA, 8'h00, 8'hb2, 5'h00, 16'h0000, 16'h0000, 3'h0);
        run(`OP_DAA, 8'h00, 8'h9a, 5'h00, 16'h0000, 16'h0000, 3'h0);
        run(`OP_INCA, 8'hff, 8'h33, 5'h00, 16'h0000, 16'h0000, 3'h0);
        run(`OP_DECA, 8'h00, 8'h33, 5'h04, 16'h0000, 16'h0000, 3'h0);
        run(`OP_ITRDL, 8'h00, 8'h33, 5'h00, 16'h12ff, 16'hbeef, 3'h0);
        run(`OP_SKZBIT, 8'hbf, 8'h21, 5'h00, 16'h0000, 16'h0000, 3'h6);
        run(`OP_SKZA, 8'h00, 8'h21, 5'h1f, 16'h0000, 16'h0000, 3'h0);
        // Every opcode except NOP once, then random traffic
        for (int i = 0; i < 340; i++) begin
            ra = $urandom;
            rb = $urandom;
            run(i < 28 ? 5'(i + 1) : 5'($urandom % 28) + 5'h01, ra[7:0], ra[15:8],
                ra[20:16], rb[15:0], rb[31:16], ra[23:21]);
        end
        tally_and_finish;
    end
endmodule
